// ==== rtl/rtc_divider_chain_counter.v ====
// Purpose: real-time counter built from a chain of up-counting divider stages
// Assumes: presetn is the power reset; no other reset reaches these registers
// Notes:   APB slave, no wait states; ready in the first access cycle of every transfer
//
// Added by the designer: the register offsets and the APB register port.
`timescale 1ns/1ps
`default_nettype none
`include "rtc_map.vh"

// Functional notes
// (RQ1) input clock selected by configuration: internal clock or external pin
// (RQ2) 32:1 and 8:1 dividers each switchable in or bypassed
// (RQ3) 16-bit prescale timer with reload counts the divided clock
// (RQ4) 32-bit main count of 10, 6, 6, 10 bit stages, high and low word
// (RQ5) every stage counts upward only
// (RQ6) every stage raises its own interrupt request
// (RQ7) all requests merged into one node request output
// (RQ8) all registers cleared only by power reset
// (RQ9) prescale plus main count form one continuous 48-bit up-counter
// (RQ10) alarm interrupt when count reaches a programmed time
// (RQ11) periodic tick interrupt paced only by the counter clock
// (RQ12) on overflow a stage reloads, requests, and steps the next stage
// (RQ13) requests latched in flags with enables; node request ORs enabled flags
module rtc_divider_chain_counter (
	// clock and power reset
	input  wire        pclk,
	input  wire        presetn,
	// apb slave
	input  wire        psel,
	input  wire        penable,
	input  wire        pwrite,
	input  wire [7:0]  paddr,
	input  wire [31:0] pwdata,
	output reg  [31:0] prdata,
	output reg         pready,
	output reg         pslverr,
	// external counter clock pin
	input  wire        ext_clk_pin,
	// interrupt node request
	output reg         node_irq
);

	// ****************************************
	// helpers
	// ****************************************

	// incremented stage value, or reload value on overflow
	function [15:0] step;
		input [15:0] val;
		input [15:0] rel;
		input        ovf;
		begin
			if (ovf) begin
				step = rel;
			end else begin
				step = val + 16'h0001;
			end
		end
	endfunction

	// ****************************************
	// state
	// ****************************************

	reg  [`RTC_CTRL_W-1:0] ctrl_q;
	reg  [15:0]            pre_q;
	reg  [15:0]            pre_rel_q;
	reg  [31:0]            cnt_q;
	reg  [31:0]            rel_q;
	reg  [31:0]            alarm_q;
	reg  [`RTC_EV_W-1:0]   status_q;
	reg  [`RTC_EV_W-1:0]   enable_q;
	reg  [4:0]             div32_q;
	reg  [2:0]             div8_q;
	reg                    ext_s1_q;
	reg                    ext_s2_q;
	reg                    ext_s3_q;

	wire [15:0]            pre_d;
	wire [31:0]            cnt_d;
	wire [`RTC_EV_W-1:0]   ev;
	reg  [`RTC_EV_W-1:0]   status_d;
	reg  [31:0]            rdata_d;
	reg                    err_d;

	// ****************************************
	// clock source and dividers
	// ****************************************

	wire ext_rise  = ext_s2_q & ~ext_s3_q;
	wire src_tick  = ctrl_q[`RTC_CTRL_RUN] & (ctrl_q[`RTC_CTRL_EXT] ? ext_rise : 1'b1); // RQ1
	wire d32_tick  = ctrl_q[`RTC_CTRL_DIV32] ? (src_tick & (div32_q == `RTC_DIV32_LAST)) : src_tick; // RQ2
	wire d8_tick   = ctrl_q[`RTC_CTRL_DIV8] ? (d32_tick & (div8_q == `RTC_DIV8_LAST)) : d32_tick; // RQ2

	// ****************************************
	// prescale timer and main count chain
	// ****************************************

	// each stage advances only when the one before overflows
	wire ovf_p  = d8_tick & (&pre_q); // RQ3
	wire ovf_0  = ovf_p & (&cnt_q[`RTC_S0_HI:0]); // RQ12
	wire ovf_1  = ovf_0 & (&cnt_q[`RTC_S1_HI:`RTC_S0_HI+1]);
	wire ovf_2  = ovf_1 & (&cnt_q[`RTC_S2_HI:`RTC_S1_HI+1]);
	wire ovf_3  = ovf_2 & (&cnt_q[`RTC_S3_HI:`RTC_S2_HI+1]);

	wire [15:0] s0_n = step({6'h00, cnt_q[`RTC_S0_HI:0]}, {6'h00, rel_q[`RTC_S0_HI:0]}, ovf_0);
	wire [15:0] s1_n = step({10'h000, cnt_q[`RTC_S1_HI:`RTC_S0_HI+1]},
		{10'h000, rel_q[`RTC_S1_HI:`RTC_S0_HI+1]}, ovf_1);
	wire [15:0] s2_n = step({10'h000, cnt_q[`RTC_S2_HI:`RTC_S1_HI+1]},
		{10'h000, rel_q[`RTC_S2_HI:`RTC_S1_HI+1]}, ovf_2);
	wire [15:0] s3_n = step({6'h00, cnt_q[`RTC_S3_HI:`RTC_S2_HI+1]},
		{6'h00, rel_q[`RTC_S3_HI:`RTC_S2_HI+1]}, ovf_3);

	// up-counting only; 48-bit chain prescale then main count
	assign pre_d = d8_tick ? step(pre_q, pre_rel_q, ovf_p) : pre_q; // RQ5 RQ9
	assign cnt_d = {ovf_2 ? s3_n[9:0] : cnt_q[`RTC_S3_HI:`RTC_S2_HI+1],
		ovf_1 ? s2_n[5:0] : cnt_q[`RTC_S2_HI:`RTC_S1_HI+1],
		ovf_0 ? s1_n[5:0] : cnt_q[`RTC_S1_HI:`RTC_S0_HI+1],
		ovf_p ? s0_n[9:0] : cnt_q[`RTC_S0_HI:0]}; // RQ4 RQ5 RQ12

	// per-stage requests; stage overflows serve as periodic ticks
	wire alarm_hit = ovf_p & (cnt_d == alarm_q); // RQ10
	assign ev = {alarm_hit, ovf_3, ovf_2, ovf_1, ovf_0, ovf_p}; // RQ6 RQ11

	// ****************************************
	// apb decode
	// ****************************************

	wire setup  = psel & ~penable;
	wire wr_acc = psel & penable & pwrite & pready & ~pslverr;
	wire wr_clr = wr_acc & (paddr == `RTC_CLEAR_OFS);

	// read data and error for the coming access phase
	always @* begin
		rdata_d = `RTC_ZERO32;
		err_d   = 1'b0;
		case (paddr)
			`RTC_CTRL_OFS:     rdata_d = {28'h0000000, ctrl_q};
			`RTC_PRE_CNT_OFS:  rdata_d = {16'h0000, pre_q};
			`RTC_PRE_REL_OFS:  rdata_d = {16'h0000, pre_rel_q};
			`RTC_CNT_LOW_OFS:  rdata_d = {16'h0000, cnt_q[15:0]};
			`RTC_CNT_HIGH_OFS: rdata_d = {16'h0000, cnt_q[31:16]};
			`RTC_REL_LOW_OFS:  rdata_d = {16'h0000, rel_q[15:0]};
			`RTC_REL_HIGH_OFS: rdata_d = {16'h0000, rel_q[31:16]};
			`RTC_ALARM_OFS:    rdata_d = alarm_q;
			`RTC_STATUS_OFS:   rdata_d = {26'h0000000, status_q};
			`RTC_CLEAR_OFS:    rdata_d = `RTC_ZERO32;
			`RTC_ENABLE_OFS:   rdata_d = {26'h0000000, enable_q};
			default:           err_d   = 1'b1;
		endcase
	end

	// sticky flags, a new event wins over a clear
	always @* begin
		status_d = (status_q & ~(wr_clr ? pwdata[`RTC_EV_W-1:0] : `RTC_ZERO_EV)) | ev; // RQ13
	end

	// ****************************************
	// registers, power reset only
	// ****************************************

	// bus response, ready in the first access cycle, no wait state
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready  <= 1'b0;
			pslverr <= 1'b0;
			prdata  <= `RTC_ZERO32;
		end else begin
			pready  <= setup;
			pslverr <= setup & err_d;
			prdata  <= setup ? rdata_d : `RTC_ZERO32;
		end
	end

	// external pin synchroniser and edge history
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ext_s1_q <= 1'b0;
			ext_s2_q <= 1'b0;
			ext_s3_q <= 1'b0;
		end else begin
			ext_s1_q <= ext_clk_pin;
			ext_s2_q <= ext_s1_q;
			ext_s3_q <= ext_s2_q;
		end
	end

	// divider prescalers
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			div32_q <= 5'h00;
			div8_q  <= 3'h0;
		end else begin
			if (src_tick && ctrl_q[`RTC_CTRL_DIV32]) begin
				div32_q <= div32_q + 5'h01;
			end
			if (d32_tick && ctrl_q[`RTC_CTRL_DIV8]) begin
				div8_q <= div8_q + 3'h1;
			end
		end
	end

	// configuration, counters and flags; software writes win over counting
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin // RQ8
			ctrl_q    <= `RTC_CTRL_RST;
			pre_q     <= `RTC_ZERO16;
			pre_rel_q <= `RTC_ZERO16;
			cnt_q     <= `RTC_ZERO32;
			rel_q     <= `RTC_ZERO32;
			alarm_q   <= `RTC_ZERO32;
			status_q  <= `RTC_ZERO_EV;
			enable_q  <= `RTC_ZERO_EV;
		end else begin
			pre_q    <= pre_d;
			cnt_q    <= cnt_d;
			status_q <= status_d;
			if (wr_acc) begin
				case (paddr)
					`RTC_CTRL_OFS:     ctrl_q           <= pwdata[`RTC_CTRL_W-1:0];
					`RTC_PRE_CNT_OFS:  pre_q            <= pwdata[15:0];
					`RTC_PRE_REL_OFS:  pre_rel_q        <= pwdata[15:0];
					`RTC_CNT_LOW_OFS:  cnt_q[15:0]      <= pwdata[15:0];
					`RTC_CNT_HIGH_OFS: cnt_q[31:16]     <= pwdata[15:0];
					`RTC_REL_LOW_OFS:  rel_q[15:0]      <= pwdata[15:0];
					`RTC_REL_HIGH_OFS: rel_q[31:16]     <= pwdata[15:0];
					`RTC_ALARM_OFS:    alarm_q          <= pwdata;
					`RTC_ENABLE_OFS:   enable_q         <= pwdata[`RTC_EV_W-1:0];
					default:           ctrl_q           <= ctrl_q;
				endcase
			end
		end
	end

	// shared node request from enabled flags
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			node_irq <= 1'b0;
		end else begin
			node_irq <= |(status_d & enable_q); // RQ7 RQ13
		end
	end

endmodule // rtc_divider_chain_counter
`default_nettype wire

// ==== rtl/rtc_map.vh ====
// Purpose: register map and constants of the real-time divider chain counter
// Assumes: 32-bit APB data, one aligned word per register
// Notes:   definitions only
`ifndef RTC_MAP_VH
`define RTC_MAP_VH

// register byte offsets
`define RTC_CTRL_OFS      8'h00
`define RTC_PRE_CNT_OFS   8'h04
`define RTC_PRE_REL_OFS   8'h08
`define RTC_CNT_LOW_OFS   8'h0C
`define RTC_CNT_HIGH_OFS  8'h10
`define RTC_REL_LOW_OFS   8'h14
`define RTC_REL_HIGH_OFS  8'h18
`define RTC_ALARM_OFS     8'h1C
`define RTC_STATUS_OFS    8'h20
`define RTC_CLEAR_OFS     8'h24
`define RTC_ENABLE_OFS    8'h28

// control bits
`define RTC_CTRL_EXT      0
`define RTC_CTRL_DIV32    1
`define RTC_CTRL_DIV8     2
`define RTC_CTRL_RUN      3
`define RTC_CTRL_W        4

// event bits: prescale, stages 0..3, alarm
`define RTC_EV_PRE        0
`define RTC_EV_ALARM      5
`define RTC_EV_W          6

// divider terminal counts
`define RTC_DIV32_LAST    5'h1F
`define RTC_DIV8_LAST     3'h7

// main count field limits (low 10, 6, 6, high 10 bits)
`define RTC_S0_HI         9
`define RTC_S1_HI         15
`define RTC_S2_HI         21
`define RTC_S3_HI         31

// reset values
`define RTC_CTRL_RST      4'h0
`define RTC_ZERO32        32'h0000_0000
`define RTC_ZERO16        16'h0000
`define RTC_ZERO_EV       6'h00

`endif

// ==== tb/rtc_chain_properties.sv ====
// Purpose: port checks of the divider chain counter
// Assumes: one clock, presetn is the power reset
// Notes:   bound to the top module
`timescale 1ns/1ps
`default_nettype none
`include "rtc_map.vh"
module rtc_chain_props (
	// clock and reset
	input wire logic        pclk,
	input wire logic        presetn,
	// apb
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pwrite,
	input wire logic [7:0]  paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic        pready,
	input wire logic        pslverr,
	// pin and interrupt
	input wire logic        ext_clk_pin,
	input wire logic        node_irq
);
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	// setup phase, mapped and unmapped
	sequence s_setup; psel && !penable; endsequence
	sequence s_bad; s_setup ##0 (paddr > `RTC_ENABLE_OFS); endsequence
	sequence s_good; s_setup ##0 (paddr <= `RTC_ENABLE_OFS && paddr[1:0] == 2'h0); endsequence
	chk_ready_after: assert property (s_setup |=> pready) else $error("no ready after setup");
	chk_ready_once: assert property (pready |=> !pready) else $error("ready held too long");
	chk_ready_access: assert property (pready |-> psel && penable && $past(psel && !penable)) else $error("stray ready");
	chk_err_unmapped: assert property (s_bad |=> pslverr && prdata == 32'h0) else $error("no error on unmapped");
	chk_err_mapped: assert property (s_good |=> !pslverr) else $error("error on mapped");
	chk_rdata_idle: assert property (!pready |-> prdata == 32'h0) else $error("data outside access");
	chk_clear_reads: assert property (pready && !pwrite && paddr == `RTC_CLEAR_OFS |-> prdata == 32'h0) else $error("clear read");
	chk_irq_reset: assert property ($rose(presetn) |-> !node_irq && !pready) else $error("outputs after reset");
endmodule // rtc_chain_props
bind rtc_divider_chain_counter rtc_chain_props u_rtc_chain_props (.pclk(pclk), .presetn(presetn), .psel(psel),
	.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
	.pslverr(pslverr), .ext_clk_pin(ext_clk_pin), .node_irq(node_irq));
`default_nettype wire

// ==== tb/rtc_divider_chain_counter_tb_top.sv ====
// Purpose: self-checking bench of the divider chain counter
// Assumes: apb slave answers after setup; external pin paces the chain, then the internal clock
// Notes:   reads queue their expectation, a monitor compares
`timescale 1ns/1ps
`default_nettype none
`include "rtc_map.vh"
module rtc_divider_chain_counter_tb_top;
	logic        pclk, presetn, psel, penable, pwrite, ext_clk_pin;
	logic [7:0]  paddr;
	logic [31:0] pwdata, v;
	wire  [31:0] prdata;
	wire         pready, pslverr, node_irq;
	logic [32:0] q[$];
	int          err_total, n_checks;
	rtc_divider_chain_counter u_rtc_divider_chain_counter (.pclk(pclk), .presetn(presetn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .ext_clk_pin(ext_clk_pin), .node_irq(node_irq));
	// clock
	initial begin
		pclk = 0;
		forever #2.5 pclk = ~pclk;
	end
	task final_report;
		$display("checks %0d errors %0d", n_checks, err_total);
		if (err_total == 0 && n_checks > 0) $display("No errors found");
		else $display("Errors were found");
		$finish;
	endtask
	task check(input logic [32:0] s, input logic [32:0] e);
		n_checks++;
		if (s !== e) begin
			err_total++;
			$display("wrong value at %0t: saw %h expected %h", $time, s, e);
		end
	endtask
	// one apb transfer, entered just after an edge
	task xfer(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [32:0] e);
		int i;
		q.push_back(e);
		psel <= 1; pwrite <= w; paddr <= a; pwdata <= d; penable <= 0;
		@(posedge pclk);
		penable <= 1;
		for (i = 0; i < 20; i++) begin
			@(posedge pclk);
			if (pready === 1'b1) break;
		end
		psel <= 0; penable <= 0;
		@(posedge pclk);
		if (i == 20) begin
			err_total++;
			final_report;
		end
	endtask
	task wr(input logic [7:0] a, input logic [31:0] d); xfer(1, a, d, 33'h0); endtask
	task rd(input logic [7:0] a, input logic [31:0] e); xfer(0, a, 32'h0, {1'b0, e}); endtask
	// edges on the external count pin
	task pulse(input int n);
		repeat (n) begin
			ext_clk_pin <= 1; repeat (4) @(posedge pclk);
			ext_clk_pin <= 0; repeat (4) @(posedge pclk);
		end
		repeat (4) @(posedge pclk);
	endtask
	// monitor of answers
	always @(posedge pclk) if (pready === 1'b1) check({pslverr, pwrite ? 32'h0 : prdata}, q.pop_front());
	// main sequence
	initial begin
		{presetn, psel, penable, pwrite, ext_clk_pin, paddr, pwdata} = '0;
		repeat (8) @(posedge pclk);
		presetn <= 1;
		void'($urandom(32'h5D36D4EB));
		v = $urandom;
		rd(`RTC_CTRL_OFS, 32'h0);
		rd(`RTC_CNT_HIGH_OFS, 32'h0);
		rd(`RTC_STATUS_OFS, 32'h0);
		xfer(0, 8'h30, 32'h0, {1'b1, 32'h0});
		wr(`RTC_ALARM_OFS, v);
		rd(`RTC_ALARM_OFS, v);
		wr(`RTC_PRE_REL_OFS, 32'h0000_FFFD);
		wr(`RTC_PRE_CNT_OFS, 32'h0000_FFFD);
		wr(`RTC_REL_LOW_OFS, 32'h0000_0005);
		wr(`RTC_CNT_LOW_OFS, 32'h0000_03FE);
		wr(`RTC_ALARM_OFS, 32'h0000_0406);
		wr(`RTC_CTRL_OFS, 32'h0000_0009);
		pulse(6);
		rd(`RTC_PRE_CNT_OFS, 32'h0000_FFFD);
		rd(`RTC_CNT_LOW_OFS, 32'h0000_0405);
		rd(`RTC_STATUS_OFS, 32'h0000_0003);
		check({32'h0, node_irq}, 33'h0);
		wr(`RTC_ENABLE_OFS, 32'h0000_0002);
		repeat (2) @(posedge pclk);
		check({32'h0, node_irq}, 33'h1);
		wr(`RTC_CLEAR_OFS, 32'h0000_003F);
		repeat (2) @(posedge pclk);
		check({32'h0, node_irq}, 33'h0);
		rd(`RTC_CLEAR_OFS, 32'h0);
		pulse(3);
		wr(`RTC_ENABLE_OFS, 32'h0000_0020);
		rd(`RTC_STATUS_OFS, 32'h0000_0021);
		repeat (2) @(posedge pclk);
		check({32'h0, node_irq}, 33'h1);
		// internal source through both dividers: about 600 ticks give two prescale steps
		wr(`RTC_CTRL_OFS, 32'h0000_000E);
		repeat (600) @(posedge pclk);
		wr(`RTC_CTRL_OFS, 32'h0000_0000);
		rd(`RTC_PRE_CNT_OFS, 32'h0000_FFFF);
		rd(`RTC_CNT_LOW_OFS, 32'h0000_0406);
		final_report;
	end
endmodule // rtc_divider_chain_counter_tb_top
`default_nettype wire
